// ===== inc/soc_pkg.sv
// =====================================================
// synthesizer output configuration word: shared constants
package soc_pkg;
  localparam int SOC_WORD_W = 32;
  localparam logic [2:0] SOC_ADDR_OUT_CFG = 3'h4; // output configuration word
  localparam logic [2:0] SOC_ADDR_MAIN = 3'h0;    // main word, loads buffered divider
  localparam logic [31:0] SOC_OUT_CFG_RST = 32'h6180b23c;
  // field positions
  localparam int SOC_ADDR_HI = 2;
  localparam int SOC_ADDR_LO = 0;
  localparam int SOC_BS_HI_HI = 25;
  localparam int SOC_BS_HI_LO = 24;
  localparam int SOC_FB_BIT = 23;
  localparam int SOC_DIV_HI = 22;
  localparam int SOC_DIV_LO = 20;
  localparam int SOC_BS_LO_HI = 19;
  localparam int SOC_BS_LO_LO = 12;
  localparam int SOC_OSC_OFF_BIT = 11;
  localparam int SOC_MUTE_TILL_LOCK_BIT = 10;
  localparam int SOC_B_SRC_BIT = 9;
  localparam int SOC_B_EN_BIT = 8;
  localparam int SOC_B_LVL_HI = 7;
  localparam int SOC_B_LVL_LO = 6;
  localparam int SOC_A_EN_BIT = 5;
  localparam int SOC_A_LVL_HI = 4;
  localparam int SOC_A_LVL_LO = 3;
  // widths and fixed values
  localparam int SOC_BS_W = 10;
  localparam int SOC_DIV_W = 3;
  localparam int SOC_RATIO_W = 8;
  localparam int SOC_LVL_W = 2;
  localparam int SOC_NUM_OUT = 2;
  localparam logic [SOC_BS_W-1:0] SOC_BS_RESERVED = 10'h000;
  localparam logic [SOC_RATIO_W-1:0] SOC_RATIO_ONE = 8'h01;
  // power level codes, -4/-1/+2/+5 dBm single ended
  localparam logic [SOC_LVL_W-1:0] SOC_LVL_M4DBM = 2'h0;
  localparam logic [SOC_LVL_W-1:0] SOC_LVL_M1DBM = 2'h1;
  localparam logic [SOC_LVL_W-1:0] SOC_LVL_P2DBM = 2'h2;
  localparam logic [SOC_LVL_W-1:0] SOC_LVL_P5DBM = 2'h3;
endpackage

// ===== rtl/soc_out_chan.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// one output driver stage: registers enable, level and path
module soc_out_chan
  import soc_pkg::*;
(
  input wire logic clk,                   // system clock
  input wire logic sys_rst,               // synchronous reset
  input wire logic clk_en,                // freezes state when low
  input wire logic cfg_en,                // enable field of the word
  input wire logic [SOC_LVL_W-1:0] cfg_level, // power level field
  input wire logic cfg_src_fund,          // 1: fundamental, 0: divided
  input wire logic mute,                  // mute request from the core
  input wire logic rst_en,                // enable value after reset
  input wire logic [SOC_LVL_W-1:0] rst_level, // level value after reset
  input wire logic rst_src,               // path value after reset
  output logic drive_on_r,                // output actually driving
  output logic [SOC_LVL_W-1:0] level_r,   // applied power level
  output logic src_fund_r                 // applied path select
);
  // =====================================================
  // registered driver state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive_on_r <= rst_en;
      level_r <= rst_level;
      src_fund_r <= rst_src;
    end else if (clk_en) begin
      drive_on_r <= cfg_en & ~mute;
      level_r <= cfg_level;
      src_fund_r <= cfg_src_fund;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/soc_out_cfg.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// output configuration word decoder of the synthesizer
// Function
// [RULE_01] words with address bits 2:0 equal to 100 load this register
// [RULE_02] band select divider is bits 25:24 above bits 19:12
// [RULE_03] divider value n divides by n; zero is reserved, controller avoids it
// [RULE_04] bit 23 picks feedback: 0 divided output, 1 fundamental
// [RULE_05] bits 22:20 give output divide ratio two to the code, 1 to 128
// [RULE_06] with double buffering on, divider code applies at next main word write
// [RULE_07] controller picks divider code from target output frequency band
// [RULE_08] bit 11 high powers the oscillator down, low enables it
// [RULE_09] bit 10 high mutes outputs until lock is detected
// [RULE_10] bit 9 picks second output path: 0 divided, 1 fundamental
// [RULE_11] bit 8 enables the second output
// [RULE_12] bits 7:6 set second output level, -4 to +5 dBm
// [RULE_13] bit 5 enables the first output
// [RULE_14] bits 4:3 set first output level, same encoding
// [RULE_15] reset value of the word is 6180b23c hex
// [RULE_16] controller writes top bits 31:29 as 011 every time
// [RULE_17] an accepted write updates all fields at once, except buffered divider; here an unbuffered divider code applies one clock before the other fields
module soc_out_cfg
  import soc_pkg::*;
(
  input wire logic clk,                          // 40 MHz system clock
  input wire logic sys_rst,                      // synchronous reset, active high
  input wire logic clk_en,                       // freezes all state when low
  input wire logic word_valid,                   // one-cycle strobe: word complete
  input wire logic [SOC_WORD_W-1:0] word_data,   // loaded configuration word
  input wire logic reg4_double_buf,              // hold divider code until main write
  input wire logic lock_detect,                  // lock detect level, asynchronous
  output logic [SOC_WORD_W-1:0] cfg_word_r,      // current word contents
  output logic [SOC_BS_W-1:0] band_sel_div_r,    // band select divider
  output logic band_sel_reserved_r,              // divider holds reserved zero
  output logic feedback_src_r,                   // 1: fundamental feedback
  output logic [SOC_DIV_W-1:0] out_div_code_r,   // applied divider code
  output logic [SOC_RATIO_W-1:0] out_div_ratio_r, // applied divide ratio
  output logic div_pending_r,                    // a buffered code waits
  output logic osc_power_off_r,                  // oscillator powered down
  output logic mute_till_lock_r,                 // mute-until-lock mode on
  output logic [SOC_NUM_OUT-1:0] out_on_r,       // [0] first, [1] second output driving
  output logic [SOC_LVL_W-1:0] first_out_level_r, // first output level
  output logic [SOC_LVL_W-1:0] second_out_level_r, // second output level
  output logic second_out_src_r                  // second output path
);
  // =====================================================
  // write decode
  logic wr_cfg;
  logic wr_main;
  assign wr_cfg = word_valid & (word_data[SOC_ADDR_HI:SOC_ADDR_LO] == SOC_ADDR_OUT_CFG); // [RULE_01]
  assign wr_main = word_valid & (word_data[SOC_ADDR_HI:SOC_ADDR_LO] == SOC_ADDR_MAIN);

  // =====================================================
  // lock detect synchroniser, second stage only is read
  logic lock_meta_r;
  logic lock_sync_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_meta_r <= 1'b0;
      lock_sync_r <= 1'b0;
    end else if (clk_en) begin
      lock_meta_r <= lock_detect;
      lock_sync_r <= lock_meta_r;
    end
  end

  // =====================================================
  // word storage, whole word in one step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_word_r <= SOC_OUT_CFG_RST; // [RULE_15]
    end else if (clk_en && wr_cfg) begin
      cfg_word_r <= word_data; // [RULE_17]
    end
  end

  // =====================================================
  // field slices of the stored word
  logic [SOC_BS_W-1:0] bs_w;
  logic [SOC_DIV_W-1:0] div_w;
  assign bs_w = {cfg_word_r[SOC_BS_HI_HI:SOC_BS_HI_LO], cfg_word_r[SOC_BS_LO_HI:SOC_BS_LO_LO]}; // [RULE_02]
  assign div_w = cfg_word_r[SOC_DIV_HI:SOC_DIV_LO];
  logic [SOC_DIV_W-1:0] rst_div;
  assign rst_div = SOC_OUT_CFG_RST[SOC_DIV_HI:SOC_DIV_LO];

  // =====================================================
  // plain settings follow the stored word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      band_sel_div_r <= {SOC_OUT_CFG_RST[SOC_BS_HI_HI:SOC_BS_HI_LO],
                         SOC_OUT_CFG_RST[SOC_BS_LO_HI:SOC_BS_LO_LO]};
      band_sel_reserved_r <= 1'b0;
      feedback_src_r <= SOC_OUT_CFG_RST[SOC_FB_BIT];
      osc_power_off_r <= SOC_OUT_CFG_RST[SOC_OSC_OFF_BIT];
      mute_till_lock_r <= SOC_OUT_CFG_RST[SOC_MUTE_TILL_LOCK_BIT];
    end else if (clk_en) begin
      band_sel_div_r <= bs_w; // [RULE_02]
      band_sel_reserved_r <= (bs_w == SOC_BS_RESERVED); // [RULE_03]
      feedback_src_r <= cfg_word_r[SOC_FB_BIT]; // [RULE_04]
      osc_power_off_r <= cfg_word_r[SOC_OSC_OFF_BIT]; // [RULE_08]
      mute_till_lock_r <= cfg_word_r[SOC_MUTE_TILL_LOCK_BIT]; // [RULE_09]
    end
  end

  // =====================================================
  // output divider code with optional double buffering
  logic [SOC_DIV_W-1:0] div_nxt;
  always_comb begin
    div_nxt = out_div_code_r;
    if (!reg4_double_buf && wr_cfg) begin
      div_nxt = word_data[SOC_DIV_HI:SOC_DIV_LO]; // [RULE_17]
    end else if (reg4_double_buf && wr_main && div_pending_r) begin
      div_nxt = div_w; // [RULE_06]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_div_code_r <= rst_div;
      out_div_ratio_r <= SOC_RATIO_ONE << rst_div;
      div_pending_r <= 1'b0;
    end else if (clk_en) begin
      out_div_code_r <= div_nxt;
      out_div_ratio_r <= SOC_RATIO_ONE << div_nxt; // [RULE_05]
      if (reg4_double_buf && wr_cfg) begin
        div_pending_r <= 1'b1; // [RULE_06]
      end else if (wr_main || !reg4_double_buf) begin
        div_pending_r <= 1'b0;
      end
    end
  end

  // =====================================================
  // per-output drivers; mute while unlocked in mute mode or oscillator off
  logic mute_all;
  assign mute_all = cfg_word_r[SOC_OSC_OFF_BIT] | (cfg_word_r[SOC_MUTE_TILL_LOCK_BIT] & ~lock_sync_r); // [RULE_09]

  logic [SOC_NUM_OUT-1:0] ch_en;
  logic [SOC_NUM_OUT-1:0] ch_src;
  logic [SOC_NUM_OUT-1:0] ch_rst_en;
  logic [SOC_NUM_OUT-1:0] ch_rst_src;
  logic [SOC_NUM_OUT-1:0][SOC_LVL_W-1:0] ch_level;
  logic [SOC_NUM_OUT-1:0][SOC_LVL_W-1:0] ch_rst_level;
  logic [SOC_NUM_OUT-1:0][SOC_LVL_W-1:0] ch_level_out;
  logic [SOC_NUM_OUT-1:0] ch_src_out;

  assign ch_en = {cfg_word_r[SOC_B_EN_BIT], cfg_word_r[SOC_A_EN_BIT]}; // [RULE_11] [RULE_13]
  assign ch_level = {cfg_word_r[SOC_B_LVL_HI:SOC_B_LVL_LO], cfg_word_r[SOC_A_LVL_HI:SOC_A_LVL_LO]}; // [RULE_12] [RULE_14]
  assign ch_src = {cfg_word_r[SOC_B_SRC_BIT], 1'b0}; // [RULE_10]
  // reset values follow the reset word; lock is not yet seen, so mute-until-lock counts as muted
  logic rst_mute;
  assign rst_mute = SOC_OUT_CFG_RST[SOC_OSC_OFF_BIT] | SOC_OUT_CFG_RST[SOC_MUTE_TILL_LOCK_BIT];
  assign ch_rst_en = {SOC_OUT_CFG_RST[SOC_B_EN_BIT], SOC_OUT_CFG_RST[SOC_A_EN_BIT]}
                     & {SOC_NUM_OUT{~rst_mute}}; // [RULE_15]
  assign ch_rst_src = {SOC_OUT_CFG_RST[SOC_B_SRC_BIT], 1'b0};
  assign ch_rst_level = {SOC_OUT_CFG_RST[SOC_B_LVL_HI:SOC_B_LVL_LO], SOC_OUT_CFG_RST[SOC_A_LVL_HI:SOC_A_LVL_LO]};

  genvar gi;
  generate
    for (gi = 0; gi < SOC_NUM_OUT; gi++) begin : g_out
      soc_out_chan u_chan (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .cfg_en(ch_en[gi]),
        .cfg_level(ch_level[gi]),
        .cfg_src_fund(ch_src[gi]),
        .mute(mute_all),
        .rst_en(ch_rst_en[gi]),
        .rst_level(ch_rst_level[gi]),
        .rst_src(ch_rst_src[gi]),
        .drive_on_r(out_on_r[gi]),
        .level_r(ch_level_out[gi]),
        .src_fund_r(ch_src_out[gi])
      );
    end
  endgenerate

  assign first_out_level_r = ch_level_out[0];
  assign second_out_level_r = ch_level_out[1];
  assign second_out_src_r = ch_src_out[1];
endmodule
`default_nettype wire

// ===== sim/soc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// controller stand-in: frames one word and strobes it
module soc_ctl_model
  import soc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire logic send, // request one word
  input wire logic [2:0] addr, // target register
  input wire logic [28:3] body, // settings
  output logic word_valid, // word strobe
  output logic [SOC_WORD_W-1:0] word_data // framed word
);
  // strobe once; between words the bus toggles to junk
  always_ff @(posedge clk) begin
    word_valid <= send & ~sys_rst;
    if (sys_rst) begin
      word_data <= 32'h0;
    end else if (send) begin
      word_data <= {3'h3, body, addr};
    end else begin
      word_data <= ~word_data;
    end
  end
endmodule
`default_nettype wire

// ===== sim/soc_out_cfg_chk.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// port checker of the configuration word decoder
module soc_out_cfg_chk
  import soc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic clk_en, // clock enable
  input wire logic word_valid, // word strobe
  input wire logic reg4_double_buf, // divider buffering mode
  input wire logic lock_detect, // lock level
  input wire logic [SOC_WORD_W-1:0] word_data, // incoming word
  input wire logic [SOC_WORD_W-1:0] cfg_word_r, // stored word
  input wire logic [SOC_BS_W-1:0] band_sel_div_r, // divider
  input wire logic [SOC_DIV_W-1:0] out_div_code_r, // code
  input wire logic [SOC_RATIO_W-1:0] out_div_ratio_r, // ratio
  input wire logic [SOC_NUM_OUT-1:0] out_on_r, // drivers
  input wire logic [SOC_LVL_W-1:0] first_out_level_r, // first level
  input wire logic [SOC_LVL_W-1:0] second_out_level_r, // second level
  input wire logic band_sel_reserved_r, // reserved divider flag
  input wire logic feedback_src_r, // feedback path
  input wire logic div_pending_r, // buffered code waits
  input wire logic osc_power_off_r, // oscillator off
  input wire logic mute_till_lock_r, // mute mode
  input wire logic second_out_src_r // second output path
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wr4, wr0;
  // accepted writes by address
  assign wr4 = clk_en && word_valid && word_data[2:0] == 3'h4;
  assign wr0 = clk_en && word_valid && word_data[2:0] == 3'h0;
  // the driver stage registers the mute seen in the cycle before its output
  sequence s_off; clk_en ##1 clk_en && cfg_word_r[11]; endsequence
  sequence s_live; clk_en ##1 clk_en && !cfg_word_r[11] && !cfg_word_r[10]; endsequence
  property p_load; wr4 |=> cfg_word_r == $past(word_data); endproperty
  a_load: assert property (p_load) else $error("word not stored");
  property p_decode; clk_en |=> band_sel_div_r == {$past(cfg_word_r[25:24]), $past(cfg_word_r[19:12])}
    && band_sel_reserved_r == (band_sel_div_r == 10'h0); endproperty
  a_decode: assert property (p_decode) else $error("divider decode wrong");
  property p_fields; clk_en |=> {feedback_src_r, osc_power_off_r, mute_till_lock_r, second_out_src_r,
    second_out_level_r, first_out_level_r} == {$past(cfg_word_r[23]), $past(cfg_word_r[11:9]),
    $past(cfg_word_r[7:6]), $past(cfg_word_r[4:3])}; endproperty
  a_fields: assert property (p_fields) else $error("field decode wrong");
  property p_held; clk_en && reg4_double_buf && !wr0 |=> $stable(out_div_code_r); endproperty
  a_held: assert property (p_held) else $error("buffered code moved");
  property p_release; wr0 && reg4_double_buf && div_pending_r |=>
    out_div_code_r == $past(cfg_word_r[22:20]) && !div_pending_r;
  endproperty
  a_release: assert property (p_release) else $error("buffered code not applied");
  property p_off; s_off |=> out_on_r == 2'h0; endproperty
  a_off: assert property (p_off) else $error("output on with oscillator off");
  property p_live; s_live |=> out_on_r == {$past(cfg_word_r[8]), $past(cfg_word_r[5])}; endproperty
  a_live: assert property (p_live) else $error("output enable wrong");
  property p_lock; (clk_en && cfg_word_r[10] && !lock_detect) [*4] |=> out_on_r == 2'h0; endproperty
  a_lock: assert property (p_lock) else $error("output on before lock");
  property p_ratio; out_div_ratio_r == (8'h01 << out_div_code_r); endproperty
  a_ratio: assert property (p_ratio) else $error("divide ratio does not match code");
endmodule
bind soc_out_cfg soc_out_cfg_chk i_chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .clk_en(clk_en),
  .word_valid(word_valid),
  .reg4_double_buf(reg4_double_buf),
  .lock_detect(lock_detect),
  .word_data(word_data),
  .cfg_word_r(cfg_word_r),
  .band_sel_div_r(band_sel_div_r),
  .out_div_code_r(out_div_code_r),
  .out_div_ratio_r(out_div_ratio_r),
  .out_on_r(out_on_r),
  .first_out_level_r(first_out_level_r),
  .second_out_level_r(second_out_level_r),
  .band_sel_reserved_r(band_sel_reserved_r),
  .feedback_src_r(feedback_src_r),
  .div_pending_r(div_pending_r),
  .osc_power_off_r(osc_power_off_r),
  .mute_till_lock_r(mute_till_lock_r),
  .second_out_src_r(second_out_src_r)
);
`default_nettype wire

// ===== sim/soc_out_cfg_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// bench: reset, then table of writes, address, buffer, mute and reset again cases
module soc_out_cfg_tb_top;
  import soc_pkg::*;
  logic clk = 0, sys_rst = 1, clk_en = 1, reg4_double_buf = 0, lock_detect = 0, send = 0;
  logic [2:0] addr = 3'h4;
  logic [31:0] w = 32'h0;
  logic word_valid, band_sel_reserved_r, feedback_src_r, div_pending_r, osc_power_off_r;
  logic mute_till_lock_r, second_out_src_r;
  logic [31:0] word_data, cfg_word_r;
  logic [9:0] band_sel_div_r;
  logic [2:0] out_div_code_r;
  logic [7:0] out_div_ratio_r;
  logic [1:0] out_on_r, first_out_level_r, second_out_level_r;
  int mismatches = 0, samples_checked = 0;
  logic [7:0] ratio_tab [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  soc_ctl_model i_ctl (
    .clk(clk),
    .sys_rst(sys_rst),
    .send(send),
    .addr(addr),
    .body(w[28:3]),
    .word_valid(word_valid),
    .word_data(word_data)
  );
  soc_out_cfg i_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .word_valid(word_valid),
    .word_data(word_data),
    .reg4_double_buf(reg4_double_buf),
    .lock_detect(lock_detect),
    .cfg_word_r(cfg_word_r),
    .band_sel_div_r(band_sel_div_r),
    .band_sel_reserved_r(band_sel_reserved_r),
    .feedback_src_r(feedback_src_r),
    .out_div_code_r(out_div_code_r),
    .out_div_ratio_r(out_div_ratio_r),
    .div_pending_r(div_pending_r),
    .osc_power_off_r(osc_power_off_r),
    .mute_till_lock_r(mute_till_lock_r),
    .out_on_r(out_on_r),
    .first_out_level_r(first_out_level_r),
    .second_out_level_r(second_out_level_r),
    .second_out_src_r(second_out_src_r)
  );
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] v);
    @(posedge clk);
    send <= 1'b1;
    addr <= a;
    w <= v;
    @(posedge clk);
    send <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    logic [31:0] v;
    repeat (7) @(posedge clk);
    #1;
    chk(cfg_word_r, SOC_OUT_CFG_RST);
    chk({out_on_r, second_out_src_r, feedback_src_r, out_div_ratio_r}, {2'h1, 1'b1, 1'b1, 8'h01});
    chk({band_sel_div_r, first_out_level_r}, {10'h10b, 2'h3});
    @(posedge clk) sys_rst <= 1'b0;
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      // one word per divider code, low divider byte never zero, top bits 011
      v = {6'h18, i[1:0], i[0], i[2:0], 8'(i + 1), 2'h0, i[1], i[2], i[1:0], ~i[0], ~i[1:0], 3'h4};
      wr(3'h4, v);
      chk(cfg_word_r, v);
      chk({band_sel_div_r, band_sel_reserved_r}, {v[25:24], v[19:12], 1'b0});
      chk({feedback_src_r, osc_power_off_r, mute_till_lock_r, div_pending_r}, {v[23], v[11:10], 1'b0});
      chk({out_div_code_r, out_div_ratio_r}, {v[22:20], ratio_tab[i]});
      chk({second_out_src_r, out_on_r, second_out_level_r, first_out_level_r},
        {v[9], v[8], v[5], v[7:6], v[4:3]});
    end
    $display("table test done");
    wr(3'h5, 32'h0);
    @(posedge clk) clk_en <= 1'b0;
    wr(3'h4, 32'h60000004);
    @(posedge clk) clk_en <= 1'b1;
    #1;
    chk(cfg_word_r, v);
    $display("ignore test done");
    @(posedge clk) reg4_double_buf <= 1'b1;
    wr(3'h4, 32'h60500824);
    chk({out_div_code_r, div_pending_r, band_sel_reserved_r}, {3'h7, 2'h3});
    chk({osc_power_off_r, out_on_r}, 3'h4);
    wr(3'h0, 32'h0);
    chk({out_div_code_r, div_pending_r, out_div_ratio_r}, {3'h5, 1'b0, 8'h20});
    $display("buffer test done");
    @(posedge clk) reg4_double_buf <= 1'b0;
    wr(3'h4, 32'h60501424);
    chk({mute_till_lock_r, out_on_r}, 3'h4);
    @(posedge clk) lock_detect <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(out_on_r, 2'h1);
    $display("mute test done");
    // reset again in mid-run: the word and its fields return to the reset word
    @(posedge clk) sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(cfg_word_r, SOC_OUT_CFG_RST);
    chk({out_on_r, second_out_src_r, out_div_code_r, div_pending_r}, {2'h1, 1'b1, 3'h0, 1'b0});
    @(posedge clk) sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({out_on_r, first_out_level_r}, {2'h1, 2'h3});
    $display("reset again test done");
    end_sim();
  end
endmodule
`default_nettype wire
